// >>> rtl/sfmio_frontend.sv
// Function
// - unknown command sends device to standby, output released, until select rises.
// - valid command makes device active until select rises.
// - single rate samples on clock rise, shifts out on clock fall.
// - both clock idle levels, mode 0 and mode 3, are accepted.
// - dual reads move two bits per clock.
// - dual commands turn lines 0 and 1 bidirectional.
// - quad reads move four bits per clock.
// - quad commands turn all four lines bidirectional, in pin order.
// - quad commands only honoured with quad enable set.
// - pause halts serial traffic; running program or erase continues.
// - hold starts at pause falling while clock low, else at clock low.
// - hold ends at pause rising while clock low, else at clock low.
// - output released from pause falling until pause returns high; once held, it stays released until hold ends.
// - data input ignored while clock and pause both low until released.
// - select rising during hold resets interface logic.
// - pause pin has no hold meaning in quad mode.
// - quad enable chooses protect and pause or data lines 2 and 3.
//
// Purpose: serial multi-line front end of a flash device, oversampling the link
// Assumes: clk much faster than the serial clock; link pins enter asynchronously
// Notes: received bytes leave through an 8-word FIFO; read bytes come from txData
`timescale 1ns/1ps
`default_nettype none

module sfmio_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    logic [AW-1:0] next_wrPtr;
    logic [AW-1:0] next_rdPtr;
    logic [AW:0] next_count;
    logic doWr;
    logic doRd;

    assign inReady = (count != (AW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign outData = mem[rdPtr];
    assign doWr = inValid && inReady;
    assign doRd = outValid && outReady;

    always_comb begin
        next_wrPtr = doWr ? AW'(wrPtr + 1'b1) : wrPtr;
        next_rdPtr = doRd ? AW'(rdPtr + 1'b1) : rdPtr;
        next_count = count;
        if (doWr && !doRd) begin
            next_count = count + 1'b1;
        end else if (doRd && !doWr) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            count <= next_count;
        end
    end

    always_ff @(posedge clk) begin
        if (doWr) begin
            mem[wrPtr] <= inData;
        end
    end
endmodule : sfmio_fifo

////////////////////////////////////////////////////////////////////////////////

module sfmio_frontend
    import sfmio_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic chipSelectN,
    input wire logic serialClock,
    input wire logic [3:0] dataLineIn,
    output logic [3:0] dataLineOut,
    output logic [3:0] dataLineOe,
    input wire logic quadEnableBit,
    input wire logic busyOp,
    output logic writeProtectN,
    output logic linkActive,
    output logic linkStandby,
    output logic holdActive,
    output logic rxOverrun,
    output logic rxValid,
    input wire logic rxReady,
    output sfmio_rx_s rxWord,
    input wire logic txValid,
    output logic txReady,
    input wire logic [7:0] txData
);
    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [5:0] syncA;
    logic [5:0] syncB;
    logic sclkPrev;
    logic csN;
    logic sclk;
    logic [3:0] dIn;
    logic sclkRise;
    logic sclkFall;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            syncA <= 6'h3f;
            syncB <= 6'h3f;
            // same level as the synchroniser reset, so no false edge after reset
            sclkPrev <= 1'b1;
        end else begin
            syncA <= {chipSelectN, serialClock, dataLineIn};
            syncB <= syncA;
            sclkPrev <= syncB[4];
        end
    end

    assign csN = syncB[5];
    assign sclk = syncB[4];
    assign dIn = syncB[3:0];

    ////////////////////////////////////////////////////////////////////////////
    // hold control
    logic holdEn;
    logic held;
    logic next_held;
    logic quadBusy;

    assign holdEn = !quadEnableBit && !quadBusy;
    assign writeProtectN = quadEnableBit ? 1'b1 : dIn[2];

    always_comb begin
        next_held = held;
        if (csN || !holdEn) begin
            next_held = 1'b0;
        end else if (!held && !dIn[3] && !sclk) begin
            next_held = 1'b1;
        end else if (held && dIn[3] && !sclk) begin
            next_held = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            held <= 1'b0;
        end else begin
            held <= next_held;
        end
    end

    assign holdActive = held;

    ////////////////////////////////////////////////////////////////////////////
    // link state, shifters and counters
    sfmio_state_e state;
    sfmio_state_e next_state;
    sfmio_cmd_s info;
    sfmio_cmd_s next_info;
    logic [7:0] cmdByte;
    logic [7:0] next_cmdByte;
    logic [7:0] inSr;
    logic [7:0] next_inSr;
    logic [3:0] inCnt;
    logic [3:0] next_inCnt;
    logic [1:0] byteCnt;
    logic [1:0] next_byteCnt;
    logic [5:0] clkCnt;
    logic [5:0] next_clkCnt;
    logic firstByte;
    logic next_firstByte;
    logic [7:0] outSr;
    logic [7:0] next_outSr;
    logic [3:0] outCnt;
    logic [3:0] next_outCnt;
    logic [3:0] drive;
    logic [3:0] next_drive;
    logic driving;
    logic next_driving;
    logic overrun;
    logic next_overrun;
    logic [2:0] inW;
    logic [7:0] shifted;
    logic [7:0] curOut;
    logic [3:0] wBits;
    logic riseOk;
    logic fallOk;
    logic pushValid;
    logic pushReady;
    sfmio_rx_s pushWord;
    sfmio_cmd_s dec;

    assign sclkRise = sclk && !sclkPrev;
    assign sclkFall = !sclk && sclkPrev;
    // paused link sees no rising clock edges, which also masks the data input; falling edges stop only once held
    assign riseOk = sclkRise && !csN && !held && !(holdEn && !dIn[3]);
    assign fallOk = sclkFall && !csN && !held;
    assign dec = sfmio_decode({cmdByte[6:0], dIn[0]});
    assign quadBusy = (state == SFMIO_ACTIVE) && (info.width == SFMIO_W4);

    always_comb begin
        inW = 3'h1;
        if (state == SFMIO_ACTIVE) begin
            if (info.addrMulti || byteCnt == 2'(SFMIO_ADDR_BYTES) || !info.isRead
                && byteCnt == 2'(SFMIO_ADDR_BYTES)) begin
                inW = info.width;
            end
        end
        unique case (inW)
            3'h2: shifted = {inSr[5:0], dIn[1:0]};
            3'h4: shifted = {inSr[3:0], dIn};
            default: shifted = {inSr[6:0], dIn[0]};
        endcase
    end

    always_comb begin
        next_state = state;
        next_info = info;
        next_cmdByte = cmdByte;
        next_inSr = inSr;
        next_inCnt = inCnt;
        next_byteCnt = byteCnt;
        next_clkCnt = clkCnt;
        next_firstByte = firstByte;
        next_outSr = outSr;
        next_outCnt = outCnt;
        next_drive = drive;
        next_driving = driving;
        next_overrun = overrun;
        pushValid = 1'b0;
        pushWord = '{firstByte, cmdByte, shifted};
        txReady = 1'b0;
        wBits = {1'b0, info.width};
        curOut = (outCnt == 4'h0) ? (txValid ? txData : SFMIO_IDLE_BYTE) : outSr;
        if (csN) begin
            // select high ends any window; mode 0 or 3 idle level is irrelevant
            next_state = SFMIO_DESEL;
            next_driving = 1'b0;
        end else begin
            unique case (state)
                SFMIO_DESEL: begin
                    next_state = SFMIO_CMD;
                    next_inCnt = 4'h0;
                    next_cmdByte = 8'h00;
                    next_overrun = 1'b0;
                end
                SFMIO_CMD: begin
                    if (riseOk) begin
                        next_cmdByte = {cmdByte[6:0], dIn[0]};
                        next_inCnt = inCnt + 4'h1;
                        if (inCnt == SFMIO_BYTE_BITS - 4'h1) begin
                            next_info = dec;
                            next_inCnt = 4'h0;
                            next_byteCnt = 2'h0;
                            next_clkCnt = 6'h00;
                            next_outCnt = 4'h0;
                            next_firstByte = 1'b1;
                            if (!dec.known || (dec.width == SFMIO_W4 && !quadEnableBit)) begin
                                next_state = SFMIO_STANDBY;
                            end else begin
                                next_state = SFMIO_ACTIVE;
                            end
                        end
                    end
                end
                SFMIO_ACTIVE: begin
                    if (riseOk) begin
                        if (clkCnt != info.prefix) begin
                            next_clkCnt = clkCnt + 6'h01;
                        end
                        if (!info.isRead || clkCnt != info.prefix) begin
                            next_inSr = shifted;
                            next_inCnt = inCnt + 4'(inW);
                            if (next_inCnt >= SFMIO_BYTE_BITS) begin
                                next_inCnt = 4'h0;
                                pushValid = 1'b1;
                                next_overrun = overrun || !pushReady;
                                next_firstByte = 1'b0;
                                if (byteCnt != 2'(SFMIO_ADDR_BYTES)) begin
                                    next_byteCnt = byteCnt + 2'h1;
                                end
                            end
                        end
                    end
                    if (fallOk && info.isRead && clkCnt == info.prefix) begin
                        txReady = (outCnt == 4'h0);
                        next_driving = 1'b1;
                        next_outSr = curOut << wBits;
                        next_outCnt = ((outCnt == 4'h0) ? SFMIO_BYTE_BITS : outCnt) - wBits;
                        unique case (info.width)
                            SFMIO_W2: next_drive = {2'b00, curOut[7:6]};
                            SFMIO_W4: next_drive = curOut[7:4];
                            default: next_drive = {2'b00, curOut[7], 1'b0};
                        endcase
                    end
                end
                SFMIO_STANDBY: begin
                    next_driving = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= SFMIO_DESEL;
            info <= '{1'b0, 1'b0, 1'b0, SFMIO_W1, 6'h00};
            cmdByte <= 8'h00;
            inSr <= 8'h00;
            inCnt <= 4'h0;
            byteCnt <= 2'h0;
            clkCnt <= 6'h00;
            firstByte <= 1'b0;
            outSr <= 8'h00;
            outCnt <= 4'h0;
            drive <= 4'h0;
            driving <= 1'b0;
            overrun <= 1'b0;
        end else begin
            state <= next_state;
            info <= next_info;
            cmdByte <= next_cmdByte;
            inSr <= next_inSr;
            inCnt <= next_inCnt;
            byteCnt <= next_byteCnt;
            clkCnt <= next_clkCnt;
            firstByte <= next_firstByte;
            outSr <= next_outSr;
            outCnt <= next_outCnt;
            drive <= next_drive;
            driving <= next_driving;
            overrun <= next_overrun;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin drivers and status
    always_comb begin
        dataLineOe = 4'h0;
        if (driving && !csN && !held && !(holdEn && !dIn[3]) && state == SFMIO_ACTIVE) begin
            unique case (info.width)
                SFMIO_W2: dataLineOe = 4'h3;
                SFMIO_W4: dataLineOe = 4'hf;
                default: dataLineOe = 4'h2;
            endcase
        end
    end

    assign dataLineOut = drive;
    assign linkActive = (state == SFMIO_ACTIVE);
    assign linkStandby = (state == SFMIO_STANDBY) || busyOp && csN;
    assign rxOverrun = overrun;

    sfmio_fifo #(
        .WIDTH(SFMIO_RX_W),
        .DEPTH(SFMIO_FIFO_DEPTH)
    ) rxFifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .inValid(pushValid),
        .inReady(pushReady),
        .inData(pushWord),
        .outValid(rxValid),
        .outReady(rxReady),
        .outData(rxWord)
    );
endmodule : sfmio_frontend

`default_nettype wire

// >>> rtl/sfmio_pkg.sv
// Purpose: shared constants, types and command decode for the flash serial front end
// Assumes: pins are sampled by a 250 MHz system clock
// Notes: command set and phase lengths are those the front end must recognise
package sfmio_pkg;
    localparam int unsigned SFMIO_CLK_MHZ = 250;
    localparam int unsigned SFMIO_SYNC_STAGES = 2;
    localparam int unsigned SFMIO_FIFO_DEPTH = 8;
    localparam int unsigned SFMIO_ADDR_BYTES = 3;
    localparam logic [7:0] SFMIO_IDLE_BYTE = 8'hff;
    localparam logic [3:0] SFMIO_BYTE_BITS = 4'h8;

    typedef enum logic [2:0] {
        SFMIO_W1 = 3'h1,
        SFMIO_W2 = 3'h2,
        SFMIO_W4 = 3'h4
    } sfmio_width_e;

    typedef enum {
        SFMIO_DESEL,
        SFMIO_CMD,
        SFMIO_ACTIVE,
        SFMIO_STANDBY
    } sfmio_state_e;

    typedef struct packed {
        logic known;
        logic isRead;
        logic addrMulti;
        sfmio_width_e width;
        logic [5:0] prefix;
    } sfmio_cmd_s;

    typedef struct packed {
        logic first;
        logic [7:0] cmd;
        logic [7:0] data;
    } sfmio_rx_s;

    localparam int unsigned SFMIO_RX_W = $bits(sfmio_rx_s);

    function automatic sfmio_cmd_s sfmio_decode(input logic [7:0] op);
        sfmio_cmd_s d;
        d = '{1'b1, 1'b0, 1'b0, SFMIO_W1, 6'h00};
        unique case (op)
            8'h03: d = '{1'b1, 1'b1, 1'b0, SFMIO_W1, 6'h18};
            8'h0b: d = '{1'b1, 1'b1, 1'b0, SFMIO_W1, 6'h20};
            8'h3b: d = '{1'b1, 1'b1, 1'b0, SFMIO_W2, 6'h20};
            8'hbb, 8'h92: d = '{1'b1, 1'b1, 1'b1, SFMIO_W2, 6'h10};
            8'h6b: d = '{1'b1, 1'b1, 1'b0, SFMIO_W4, 6'h20};
            8'heb, 8'h94: d = '{1'b1, 1'b1, 1'b1, SFMIO_W4, 6'h0c};
            8'h05, 8'h35, 8'h15, 8'h9f: d = '{1'b1, 1'b1, 1'b0, SFMIO_W1, 6'h00};
            8'ha2: d = '{1'b1, 1'b0, 1'b0, SFMIO_W2, 6'h00};
            8'h32: d = '{1'b1, 1'b0, 1'b0, SFMIO_W4, 6'h00};
            8'h06, 8'h04, 8'h50, 8'h01, 8'h11, 8'h02, 8'h81, 8'h20, 8'h52,
            8'hd8, 8'h60, 8'hc7, 8'hb9, 8'hab, 8'h66, 8'h99: d = d;
            default: d.known = 1'b0;
        endcase
        return d;
    endfunction : sfmio_decode
endpackage : sfmio_pkg

// >>> dv/sfmio_frontend_monitor.sv
// Purpose: port checks of the flash link front end
// Assumes: one clock domain, synchronous active-high reset
// Notes: bound into every front end instance
`timescale 1ns/1ps
`default_nettype none
module sfmio_frontend_monitor (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic chipSelectN,
    input wire logic serialClock,
    input wire logic [3:0] dataLineOut,
    input wire logic [3:0] dataLineOe,
    input wire logic quadEnableBit,
    input wire logic writeProtectN,
    input wire logic linkActive,
    input wire logic linkStandby,
    input wire logic holdActive,
    input wire logic txReady
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence selFall;
        $fell(chipSelectN);
    endsequence
    sequence linkIdle;
        !linkActive && !linkStandby;
    endsequence
    sequence outMoved;
        !chipSelectN && dataLineOe != 4'h0 && $changed(dataLineOut);
    endsequence
    AST_DESEL_QUIET: assert property (chipSelectN [*4] |-> dataLineOe == 4'h0)
        else $error("lines driven while deselected");
    AST_STANDBY_HIGHZ: assert property (linkStandby |-> dataLineOe == 4'h0)
        else $error("lines driven in standby");
    AST_SEL_CLEARS: assert property (selFall |-> ##[1:4] linkIdle)
        else $error("select fall left link state set");
    AST_ACTIVE_ENDS: assert property ($rose(chipSelectN) |-> ##[1:4] !linkActive)
        else $error("active after select rise");
    AST_HOLD_HIGHZ: assert property (holdActive |-> dataLineOe == 4'h0)
        else $error("lines driven in hold");
    AST_QUAD_NO_HOLD: assert property (quadEnableBit [*2] |-> !holdActive)
        else $error("hold with quad enabled");
    AST_WP_FUNCTION: assert property (quadEnableBit |-> writeProtectN)
        else $error("protect active with quad enabled");
    AST_UPPER_LINES: assert property (dataLineOe[3:2] != 2'b00 |-> quadEnableBit)
        else $error("upper lines driven without quad enable");
    AST_SHIFT_ON_FALL: assert property (outMoved |-> !serialClock && !$past(serialClock))
        else $error("output moved off the falling edge");
    AST_TX_ON_FALL: assert property (txReady |-> !serialClock)
        else $error("byte taken while link clock high");
    AST_DESEL_NO_HOLD: assert property (chipSelectN [*4] |-> !holdActive)
        else $error("hold kept after deselect");
endmodule : sfmio_frontend_monitor
bind sfmio_frontend sfmio_frontend_monitor mon (.clk, .sys_rst, .chipSelectN, .serialClock,
    .dataLineOut, .dataLineOe, .quadEnableBit, .writeProtectN, .linkActive, .linkStandby,
    .holdActive, .txReady);
`default_nettype wire

// >>> dv/sfmio_host_model.sv
// Purpose: behavioural host controller on the flash link pins
// Assumes: serial half period of 8 system clocks, tasks start 1 ns after an edge
// Notes: in single-line transfers released line 1, and at stop lines 0 and 1, show the inverse of their last host value
`timescale 1ns/1ps
`default_nettype none
module sfmio_host_model (
    input wire logic clk,
    input wire logic [3:0] dataLineOut,
    input wire logic [3:0] dataLineOe,
    output logic chipSelectN,
    output logic serialClock,
    output logic [3:0] dataLineIn
);
    logic [3:0] hostVal = 4'hf;
    logic [3:0] lastOe = 4'h0;
    logic pauseN = 1'b1;
    logic mode = 1'b0;
    // wire level from the device's enables; the host value shows wherever the device releases a line
    assign dataLineIn = (dataLineOe & dataLineOut) | (~dataLineOe & hostVal);
    initial begin
        chipSelectN = 1'b1;
        serialClock = 1'b0;
    end
    task automatic pin(input logic c, input logic p);
        serialClock = c;
        pauseN = p;
        hostVal[3] = p;
        repeat (8) @(posedge clk);
        #1;
    endtask : pin
    task automatic start(input logic m);
        mode = m;
        pin(m, 1'b1);
        chipSelectN = 1'b0;
        repeat (8) @(posedge clk);
        #1;
    endtask : start
    task automatic stop();
        if (!mode) pin(1'b0, pauseN);
        chipSelectN = 1'b1;
        hostVal[1:0] = ~hostVal[1:0];
        repeat (8) @(posedge clk);
        #1;
    endtask : stop
    task automatic xfer(input int w, input logic [7:0] tx, output logic [7:0] rx);
        logic [7:0] sh;
        sh = tx;
        rx = 8'h00;
        repeat (8 / w) begin
            serialClock = 1'b0;
            hostVal = (w == 4) ? sh[7:4] : {pauseN, 1'b1, (w == 2) ? sh[7:6] : {~hostVal[1], sh[7]}};
            sh = sh << w;
            repeat (8) @(posedge clk);
            #1 serialClock = 1'b1;
            // sample where the edge rises
            if (w == 1) rx = {rx[6:0], dataLineIn[1]};
            else if (w == 2) rx = {rx[5:0], dataLineIn[1:0]};
            else rx = {rx[3:0], dataLineIn};
            lastOe = dataLineOe;
            repeat (8) @(posedge clk);
            #1;
        end
    endtask : xfer
endmodule : sfmio_host_model
`default_nettype wire

// >>> dv/tb.sv
// Purpose: self-checking bench of the flash link front end
// Assumes: host model drives a 64 ns link clock
// Notes: queues hold the read bytes and the received words expected
`timescale 1ns/1ps
`default_nettype none
module tb
    import sfmio_pkg::*;
;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic quadEnableBit = 1'b0;
    logic rxReady = 1'b1;
    logic txValid = 1'b0;
    logic [7:0] txData = 8'h00;
    logic popPend = 1'b0;
    logic busyOp = 1'b0;
    logic chipSelectN, serialClock, writeProtectN, linkActive, linkStandby;
    logic holdActive, rxOverrun, rxValid, txReady;
    logic [3:0] dataLineIn, dataLineOut, dataLineOe;
    sfmio_rx_s rxWord;
    int num_errors = 0;
    int tests_run = 0;
    logic [7:0] txQ[$];
    sfmio_rx_s gotQ[$];
    sfmio_rx_s expQ[$];
    logic [7:0] badT [4] = '{8'h42, 8'h6b, 8'heb, 8'h32};
    logic [7:0] cmdT [8] = '{8'h03, 8'h0b, 8'h3b, 8'hbb, 8'h92, 8'h6b, 8'heb, 8'h94};
    int dwT [8] = '{1, 1, 2, 2, 2, 4, 4, 4};
    int pwT [8] = '{1, 1, 1, 2, 2, 1, 4, 4};
    int pnT [8] = '{3, 4, 4, 4, 4, 4, 6, 6};
    logic [7:0] wrT [3] = '{8'h02, 8'ha2, 8'h32};
    int wwT [3] = '{1, 2, 4};
    initial forever #2 clk = ~clk;
    sfmio_frontend dut (.clk(clk), .sys_rst(sys_rst), .chipSelectN(chipSelectN),
        .serialClock(serialClock), .dataLineIn(dataLineIn), .dataLineOut(dataLineOut),
        .dataLineOe(dataLineOe), .quadEnableBit(quadEnableBit), .busyOp(busyOp),
        .writeProtectN(writeProtectN), .linkActive(linkActive), .linkStandby(linkStandby),
        .holdActive(holdActive), .rxOverrun(rxOverrun), .rxValid(rxValid), .rxReady(rxReady),
        .rxWord(rxWord), .txValid(txValid), .txReady(txReady), .txData(txData));
    sfmio_host_model host (.clk(clk), .dataLineOut(dataLineOut), .dataLineOe(dataLineOe),
        .chipSelectN(chipSelectN), .serialClock(serialClock), .dataLineIn(dataLineIn));
    // read byte supply, popped the cycle after a take
    always @(posedge clk) begin
        #1;
        if (popPend && txQ.size() > 0) void'(txQ.pop_front());
        popPend = txReady;
        txValid = txQ.size() > 0;
        txData = (txQ.size() > 0) ? txQ[0] : 8'h00;
    end
    // settled values, the same ones the fifo pops on at the next rising edge
    always @(negedge clk) begin
        if (rxValid === 1'b1 && rxReady) gotQ.push_back(rxWord);
    end
    ////////////////////////////////////////
    task automatic check(input logic [16:0] got, input logic [16:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic rd(input int w, input logic [7:0] e);
        logic [7:0] r;
        host.xfer(w, 8'h00, r);
        check(r, e);
        check(host.lastOe, (w == 1) ? 4'h2 : 4'((1 << w) - 1));
    endtask : rd
    task automatic fin();
        host.stop();
        txQ.delete();
    endtask : fin
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        report_and_stop();
    end
    initial begin
        logic [7:0] r;
        logic [7:0] b [2];
        void'($urandom(32'h6422));
        repeat (3) @(posedge clk);
        #1 sys_rst = 1'b0;
        check({linkActive, dataLineOe}, 5'h00);
        b[0] = 8'($urandom);
        b[1] = {2'b10, 6'($urandom)};
        txQ = '{b[0], b[1]};
        host.start(1'b0);
        host.xfer(1, 8'h05, r);
        rd(1, b[0]);
        host.pin(1'b0, 1'b1);
        host.pin(1'b0, 1'b0);
        check({holdActive, dataLineOe}, 5'h10);
        host.pin(1'b1, 1'b0);
        host.pin(1'b0, 1'b0);
        host.pin(1'b0, 1'b1);
        check({holdActive, dataLineOe}, 5'h02);
        host.pin(1'b1, 1'b1);
        check(dataLineIn[1], b[1][7]);
        host.pin(1'b1, 1'b0);
        check(holdActive, 1'b0);
        host.pin(1'b0, 1'b0);
        check(holdActive, 1'b1);
        fin();
        check({holdActive, linkActive}, 2'b00);
        busyOp = 1'b1;
        repeat (2) @(posedge clk);
        #1 check(linkStandby, 1'b1);
        busyOp = 1'b0;
        host.pin(1'b0, 1'b1);
        check(linkStandby, 1'b0);
        $display("test hold done");
        for (int m = 0; m < 2; m++) begin
            b[0] = 8'($urandom);
            b[1] = 8'($urandom);
            txQ = '{b[0], b[1]};
            host.start(m[0]);
            host.xfer(1, 8'h05, r);
            check(linkActive, 1'b1);
            rd(1, b[0]);
            rd(1, b[1]);
            fin();
            check(linkActive, 1'b0);
        end
        $display("test status read done");
        foreach (badT[i]) begin
            host.start(1'b0);
            check(linkStandby, 1'b0);
            host.xfer(1, badT[i], r);
            host.xfer(1, 8'h00, r);
            check({linkStandby, linkActive, dataLineOe}, 6'h20);
            fin();
        end
        $display("test refused command done");
        quadEnableBit = 1'b1;
        foreach (cmdT[i]) begin
            b[0] = 8'($urandom);
            b[1] = 8'($urandom);
            txQ = '{b[0], b[1]};
            host.start(1'b0);
            host.xfer(1, cmdT[i], r);
            repeat (pnT[i]) host.xfer(pwT[i], 8'($urandom), r);
            rd(dwT[i], b[0]);
            rd(dwT[i], b[1]);
            fin();
        end
        $display("test multi line read done");
        foreach (wrT[i]) begin
            rxReady = 1'b0;
            gotQ.delete();
            expQ.delete();
            host.start(1'b0);
            host.xfer(1, wrT[i], r);
            for (int k = 0; k < 9; k++) begin
                b[0] = 8'($urandom);
                host.xfer((k < 3) ? 1 : wwT[i], b[0], r);
                if (k < 8) expQ.push_back('{k == 0, wrT[i], b[0]});
            end
            check(writeProtectN, 1'b1);
            fin();
            check(rxOverrun, 1'b1);
            rxReady = 1'b1;
            repeat (20) @(posedge clk);
            #1 check(17'(gotQ.size()), 17'h8);
            foreach (expQ[k]) check((k < gotQ.size()) ? gotQ[k] : 17'h0, expQ[k]);
            check(rxValid, 1'b0);
        end
        $display("test write fill and drain done");
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
